// ===== shared/otp_hdr_consts.svh
// Purpose: constants of the boot image header loader
// Assumes: image addresses are byte addresses, word index is byte/4
// Notes: definitions only
`ifndef OTP_HDR_CONSTS_SVH
`define OTP_HDR_CONSTS_SVH

// ***********************************************
// image layout
// ***********************************************
`define OH_WORDS 14'd8192
`define OH_VEC_BASE 16'h0000
`define OH_VEC_WORDS 64
`define OH_HDR_BASE 16'h7f00
`define OH_HDR_WORDS 64
`define OH_DBG_ADR 16'h7ffc
`define OH_LEN_ADR 16'h7ff8
`define OH_RSVD_ADR 16'h7ff4
`define OH_BD0_ADR 16'h7fd4
`define OH_BD1_ADR 16'h7fd8
`define OH_SIGSEL_ADR 16'h7fd0
`define OH_SIG_ADR 16'h7f94
`define OH_SIG_WORDS 15
`define OH_TRIM_ADR 16'h7f90
`define OH_TRIM_WORDS 6
`define OH_CAL_ADR 16'h7f78
`define OH_SLEEP_ADR 16'h7f74
`define OH_PKG_ADR 16'h7f70
`define OH_CRC_ADR 16'h7f0c
`define OH_IQ_ADR 16'h7f08
`define OH_APP2_ADR 16'h7f04
`define OH_APP1_ADR 16'h7f00

// ***********************************************
// codes
// ***********************************************
`define OH_APP1_VAL 32'h1234a5a5
`define OH_APP2_VAL 32'ha5a51234
`define OH_CODE_AA 8'haa
`define OH_CODE_55 8'h55
`define OH_CODE_FF 8'hff
`define OH_CODE_99 8'h99
`define OH_CAL_MAGIC 16'ha5a5

// ***********************************************
// load sequence and register offsets
// ***********************************************
`define OH_STEPS 6'd33
`define OH_STEP_TRIM 6'd10
`define OH_STEP_SIG 6'd18
`define OH_REG_CTRL 8'h00
`define OH_REG_STATUS 8'h04
`define OH_REG_LEN 8'h08
`define OH_REG_CAL 8'h0c
`define OH_REG_BD_HI 8'h10
`define OH_REG_BD_LO 8'h14
`define OH_REG_TRIM 8'h20
`define OH_REG_SIG 8'h40
`define OH_CTRL_RST 32'h0000_0000

`endif

// ===== shared/otp_hdr_pkg.sv
// Purpose: types of the boot image header loader
// Assumes: used with otp_hdr_consts.svh
// Notes: carriers are packed structs
package otp_hdr_pkg;

  typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_COPY, ST_RUN} boot_st_e;
  typedef enum logic [1:0] {SIG_NONE, SIG_MD5, SIG_SHA1, SIG_CRC32} sig_alg_e;
  typedef enum logic [1:0] {PKG_KIND0, PKG_KIND1, PKG_KIND2, PKG_BARE_DIE_PACKAGE} pkg_e;
  typedef enum logic {SLEEP_SLOW_CRYSTAL_OSC, SLEEP_PRECISION_RC_OSC} sleep_src_e;
  typedef enum logic [1:0] {REMAP_ROM, REMAP_SYSRAM, REMAP_RETRAM} remap_e;

  // otp array read request and answer
  typedef struct packed {
    logic req;
    logic [12:0] addr;
  } otp_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] data;
  } otp_rsp_s;

  // system ram write port
  typedef struct packed {
    logic we;
    logic [12:0] addr;
    logic [31:0] data;
  } ram_wr_s;

  // classic wishbone slave side
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_in_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_out_s;

  // decoded header contents
  typedef struct packed {
    logic app_present;
    logic debug_en;
    sleep_src_e sleep_src;
    pkg_e pkg;
    sig_alg_e sig;
    logic cal_done;
    logic [5:0] cal_valid;
    logic [13:0] copy_len;
    logic [63:0] bd_addr;
  } hdr_cfg_s;

endpackage : otp_hdr_pkg

// ===== hdl/otp_image_header_loader.sv
// Purpose: reads the image header at boot or wake, decodes it, mirrors code
// Assumes: otp and ram partners run on clk; wishbone classic slave
// Notes: otp answers one word per ack; ram write held until ram_ready
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`include "otp_hdr_consts.svh"

module otp_image_header_loader
  import otp_hdr_pkg::*;
#(
  parameter int STEPS = 33
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic start,
  output otp_req_s otp_o,
  input wire otp_rsp_s otp_i,
  output ram_wr_s ram_o,
  input wire logic ram_ready,
  input wire wb_in_s wb_i,
  output wb_out_s wb_o,
  output hdr_cfg_s cfg,
  output logic normal_mode,
  output logic busy,
  output logic done,
  output logic cpu_restart,
  output remap_e remap
);

  // *********************************************
  // state
  // *********************************************
  typedef struct packed {
    boot_st_e st;
    logic [5:0] step;
    logic [13:0] idx;
    logic wr;
    logic [31:0] ram_d;
    logic ack;
    logic [31:0] wb_dat;
    logic dev_ret;
    logic done;
    logic rst_pulse;
    remap_e remap;
    logic normal;
    hdr_cfg_s cfg;
    logic [STEPS-1:0][31:0] raw;
  } state_s;

  state_s s_r;
  state_s s_nxt;
  logic go;
  logic [31:0] rd_mux;
  logic [5:0] roff;

  // *********************************************
  // helpers
  // *********************************************
  // whole word must hold the byte four times
  function automatic logic rep(input logic [31:0] w, input logic [7:0] b);
    rep = (w == {4{b}});
  endfunction : rep

  function automatic logic [12:0] widx(input logic [15:0] badr);
    widx = badr[14:2];
  endfunction : widx

  // header word fetched at each load step
  function automatic logic [12:0] hdr_adr(input logic [5:0] s);
    logic [15:0] a;
    a = 16'h0000;
    case (s)
      6'd0: a = `OH_APP1_ADR;
      6'd1: a = `OH_APP2_ADR;
      6'd2: a = `OH_DBG_ADR;
      6'd3: a = `OH_LEN_ADR;
      6'd4: a = `OH_BD0_ADR;
      6'd5: a = `OH_BD1_ADR;
      6'd6: a = `OH_SIGSEL_ADR;
      6'd7: a = `OH_CAL_ADR;
      6'd8: a = `OH_SLEEP_ADR;
      6'd9: a = `OH_PKG_ADR;
      6'd16: a = `OH_CRC_ADR;
      6'd17: a = `OH_IQ_ADR;
      default: begin
        if (s < `OH_STEP_SIG) begin
          // trims walk downward from the top trim
          a = `OH_TRIM_ADR - {8'h00, s - `OH_STEP_TRIM, 2'b00};
        end else begin
          a = `OH_SIG_ADR + {8'h00, s - `OH_STEP_SIG, 2'b00};
        end
      end
    endcase
    hdr_adr = widx(a);
  endfunction : hdr_adr

  // decode of the captured words
  function automatic hdr_cfg_s decode(input logic [STEPS-1:0][31:0] r);
    hdr_cfg_s c;
    c = '0;
    c.app_present = (r[0] == `OH_APP1_VAL) && (r[1] == `OH_APP2_VAL);
    // only 0xaa in all four bytes turns debug off, anything else keeps it
    c.debug_en = !rep(r[2], `OH_CODE_AA);
    // clamp so a corrupt length cannot run past the array
    c.copy_len = (r[3] > {18'h0, `OH_WORDS}) ? `OH_WORDS : r[3][13:0];
    // lowest byte address sits in lane 0, so it leads the string
    c.bd_addr = {r[4][7:0], r[4][15:8], r[4][23:16], r[4][31:24],
                 r[5][7:0], r[5][15:8], r[5][23:16], r[5][31:24]};
    if (rep(r[6], `OH_CODE_AA)) begin
      c.sig = SIG_MD5;
    end else if (rep(r[6], `OH_CODE_55)) begin
      c.sig = SIG_SHA1;
    end else if (rep(r[6], `OH_CODE_FF)) begin
      c.sig = SIG_CRC32;
    end else begin
      c.sig = SIG_NONE;
    end
    c.cal_done = (r[7][31:16] == `OH_CAL_MAGIC);
    c.cal_valid = c.cal_done ? r[7][5:0] : 6'h00;
    c.sleep_src = rep(r[8], `OH_CODE_AA) ? SLEEP_PRECISION_RC_OSC
                                         : SLEEP_SLOW_CRYSTAL_OSC;
    if (rep(r[9], `OH_CODE_AA)) begin
      c.pkg = PKG_KIND1;
    end else if (rep(r[9], `OH_CODE_55)) begin
      c.pkg = PKG_KIND2;
    end else if (rep(r[9], `OH_CODE_99)) begin
      c.pkg = PKG_BARE_DIE_PACKAGE;
    end else begin
      c.pkg = PKG_KIND0;
    end
    decode = c;
  endfunction : decode

  // *********************************************
  // register read mux
  // *********************************************
  assign roff = wb_i.adr[7:2];
  always_comb begin
    rd_mux = 32'h0000_0000; // unmapped reads as zero
    if (wb_i.adr == `OH_REG_CTRL) begin
      rd_mux = {30'h0, s_r.dev_ret, 1'b0};
    end else if (wb_i.adr == `OH_REG_STATUS) begin
      // status packs the decoded flags, done on top at bit 16
      rd_mux = {15'h0, s_r.done, busy, s_r.cfg.app_present, s_r.normal,
                s_r.cfg.debug_en, s_r.cfg.sleep_src, s_r.cfg.pkg, s_r.cfg.sig,
                s_r.cfg.cal_done, s_r.cfg.cal_valid};
    end else if (wb_i.adr == `OH_REG_LEN) begin
      rd_mux = {18'h0, s_r.cfg.copy_len};
    end else if (wb_i.adr == `OH_REG_CAL) begin
      rd_mux = s_r.raw[7];
    end else if (wb_i.adr == `OH_REG_BD_HI) begin
      rd_mux = s_r.cfg.bd_addr[63:32];
    end else if (wb_i.adr == `OH_REG_BD_LO) begin
      rd_mux = s_r.cfg.bd_addr[31:0];
    end else if (roff >= 6'd8 && roff < 6'd16) begin
      // six trims, then checksum and iq trim
      rd_mux = s_r.raw[6'd2 + roff];
    end else if (roff >= 6'd16 && roff < 6'd31) begin
      rd_mux = s_r.raw[6'd2 + roff];
    end
  end

  // *********************************************
  // next state
  // *********************************************
  always_comb begin
    go = 1'b0;
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.rst_pulse = 1'b0;
    // classic single cycle: one ack, then a gap
    if (wb_i.cyc && wb_i.stb && !s_r.ack) begin
      s_nxt.ack = 1'b1;
      s_nxt.wb_dat = rd_mux;
      if (wb_i.we && wb_i.sel[0] && wb_i.adr == `OH_REG_CTRL) begin
        s_nxt.dev_ret = wb_i.dat[1];
        go = wb_i.dat[0];
      end
    end
    case (s_r.st)
      ST_IDLE: begin
        if (start || go) begin
          s_nxt.st = ST_HDR;
          s_nxt.step = 6'd0;
          s_nxt.done = 1'b0;
          s_nxt.remap = REMAP_ROM;
        end
      end
      ST_HDR: begin
        if (otp_i.ack) begin
          s_nxt.raw[s_r.step] = otp_i.data;
          if (s_r.step == `OH_STEPS - 6'd1) begin
            s_nxt.cfg = decode(s_nxt.raw);
            // blank image fails the flags and stays in development
            s_nxt.normal = s_nxt.cfg.app_present;
            s_nxt.idx = 14'd0;
            s_nxt.wr = 1'b0;
            s_nxt.st = (s_nxt.cfg.app_present && s_nxt.cfg.copy_len != 14'd0) ? ST_COPY : ST_RUN;
          end else begin
            s_nxt.step = s_r.step + 6'd1;
          end
        end
      end
      ST_COPY: begin
        // one word read, then held on the ram port until taken
        if (!s_r.wr) begin
          if (otp_i.ack) begin
            s_nxt.ram_d = otp_i.data;
            s_nxt.wr = 1'b1;
          end
        end else if (ram_ready) begin
          s_nxt.wr = 1'b0;
          s_nxt.idx = s_r.idx + 14'd1;
          if (s_r.idx + 14'd1 == s_r.cfg.copy_len) begin
            s_nxt.st = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        s_nxt.rst_pulse = 1'b1;
        s_nxt.done = 1'b1;
        // normal runs the mirror, development the retention ram when dev_ret is set, else the mirror
        s_nxt.remap = s_r.normal ? REMAP_SYSRAM
                    : (s_r.dev_ret ? REMAP_RETRAM : REMAP_SYSRAM);
        s_nxt.st = ST_IDLE;
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
  end

  // clock enable low freezes everything
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // *********************************************
  // outputs
  // *********************************************
  assign otp_o.req = (s_r.st == ST_HDR) || (s_r.st == ST_COPY && !s_r.wr);
  assign otp_o.addr = (s_r.st == ST_HDR) ? hdr_adr(s_r.step) : s_r.idx[12:0];
  assign ram_o.we = (s_r.st == ST_COPY) && s_r.wr;
  assign ram_o.addr = s_r.idx[12:0];
  assign ram_o.data = s_r.ram_d;
  assign wb_o.ack = s_r.ack;
  assign wb_o.dat = s_r.wb_dat;
  assign cfg = s_r.cfg;
  assign normal_mode = s_r.normal;
  assign busy = (s_r.st != ST_IDLE);
  assign done = s_r.done;
  assign cpu_restart = s_r.rst_pulse;
  assign remap = s_r.remap;

  // *********************************************
  // checks
  // *********************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // the array must see a steady address until it answers
  property p_otp_hold;
    otp_o.req && !otp_i.ack |=> otp_o.req && $stable(otp_o.addr);
  endproperty
  a_otp_hold: assert property (p_otp_hold) else $error("otp request dropped early");

  property p_hdr_range;
    s_r.st == ST_HDR |-> otp_o.addr >= widx(`OH_HDR_BASE);
  endproperty
  a_hdr_range: assert property (p_hdr_range) else $error("header read below header");

  property p_app;
    $rose(s_r.done) |-> s_r.normal == (s_r.raw[0] == `OH_APP1_VAL && s_r.raw[1] == `OH_APP2_VAL);
  endproperty
  a_app: assert property (p_app) else $error("mode does not follow flags");

  property p_dbg;
    $rose(s_r.done) |-> cfg.debug_en == (s_r.raw[2] != 32'haaaaaaaa);
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug enable wrong");

  property p_len;
    ram_o.we |-> s_r.idx < cfg.copy_len;
  endproperty
  a_len: assert property (p_len) else $error("copy past length");

  property p_ram_hold;
    ram_o.we && !ram_ready |=> ram_o.we && $stable(ram_o.addr) && $stable(ram_o.data);
  endproperty
  a_ram_hold: assert property (p_ram_hold) else $error("ram write not held");

  property p_cal;
    $rose(s_r.done) |-> cfg.cal_done == (s_r.raw[7][31:16] == 16'ha5a5);
  endproperty
  a_cal: assert property (p_cal) else $error("calibration flag wrong");

  property p_sig;
    $rose(s_r.done) && s_r.raw[6] == 32'h55555555 |-> cfg.sig == SIG_SHA1;
  endproperty
  a_sig: assert property (p_sig) else $error("signature decode wrong");

  property p_remap;
    cpu_restart && !normal_mode |-> remap != REMAP_ROM ##1 !cpu_restart;
  endproperty
  a_remap: assert property (p_remap) else $error("development restart not remapped");

  // flag decodes checked against the raw words once per load
  property p_sleep;
    $rose(s_r.done) |-> (cfg.sleep_src == SLEEP_PRECISION_RC_OSC) == (s_r.raw[8] == 32'haaaaaaaa);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep source decode wrong");

  property p_pkg;
    $rose(s_r.done) && s_r.raw[9] == 32'h99999999 |-> cfg.pkg == PKG_BARE_DIE_PACKAGE;
  endproperty
  a_pkg: assert property (p_pkg) else $error("package decode wrong");

  // without the magic no trim may be claimed valid
  property p_cal_none;
    $rose(s_r.done) && s_r.raw[7][31:16] != 16'ha5a5 |-> cfg.cal_valid == 6'h00;
  endproperty
  a_cal_none: assert property (p_cal_none) else $error("trim valid without calibration");

  // development mode never writes the mirror
  property p_copy_mode;
    ram_o.we |-> normal_mode;
  endproperty
  a_copy_mode: assert property (p_copy_mode) else $error("copy outside normal mode");

  property p_wb_ack;
    wb_o.ack |=> !wb_o.ack;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("ack longer than one cycle");

  // main scenarios: both modes, both targets, a stalled ram, a bus access
  c_normal: cover property (cpu_restart && normal_mode);
  c_retram: cover property (cpu_restart && remap == REMAP_RETRAM);
  c_dev: cover property (cpu_restart && !normal_mode);
  c_stall: cover property (ram_o.we && !ram_ready);
  c_wb: cover property (wb_o.ack);

endmodule : otp_image_header_loader

// ===== sim/otp_ram_model.sv
// Purpose: behavioural otp array and system ram beside the loader
// Assumes: one clock; the bench fills mem and reads ram by hierarchy
// Notes: slow stretches otp answers and toggles ram ready
`timescale 1ns/1ns
module otp_ram_model
  import otp_hdr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire otp_req_s req,
  output otp_rsp_s rsp,
  input wire ram_wr_s wr,
  output logic ready
);
  logic [31:0] mem [8192]; // 8k words of 32 bits
  logic [31:0] ram [8192];
  logic [31:0] last;
  logic [1:0] cnt;
  int writes;

  // ************************
  // otp read port
  // ************************
  // idle data is inverted so a stale word can never pass for an answer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp <= '0;
      last <= '0;
      cnt <= '0;
    end else if (req.req && !rsp.ack && cnt == (slow ? 2'd3 : 2'd0)) begin
      rsp <= '{1'b1, mem[req.addr]}; // blank cells read zero
      last <= mem[req.addr];
      cnt <= '0;
    end else begin
      rsp <= '{1'b0, ~last};
      cnt <= (req.req && !rsp.ack) ? cnt + 2'd1 : 2'd0;
    end
  end

  // ************************
  // system ram write port
  // ************************
  // slow ready makes the loader hold a write for up to two cycles
  // plain always: the bench also clears ram by hierarchy
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ready <= 1'b0;
      writes <= 0;
    end else begin
      ready <= slow ? ~ready : 1'b1;
      if (wr.we && ready) begin
        ram[wr.addr] <= wr.data;
        writes <= writes + 1;
      end
    end
  end
endmodule : otp_ram_model

// ===== sim/test_otp_image_header_loader.sv
// Purpose: self-checking bench of the image header loader
// Assumes: model answers on clk; ce held high throughout
// Notes: images are written straight into the model array
`timescale 1ns/1ns
module test_otp_image_header_loader
  import otp_hdr_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic start = 1'b0;
  logic slow = 1'b0;
  wb_in_s wb_i = '0;
  otp_req_s otp_o;
  otp_rsp_s otp_i;
  ram_wr_s ram_o;
  logic ram_ready;
  wb_out_s wb_o;
  hdr_cfg_s cfg;
  logic normal_mode;
  logic busy;
  logic done;
  logic cpu_restart;
  remap_e remap;
  int fail_count = 0;
  int compares = 0;
  int restarts = 0;
  logic [31:0] rd;
  logic [7:0] sc [5] = '{8'h00, 8'haa, 8'h55, 8'hff, 8'h12};
  logic [7:0] pc [5] = '{8'h00, 8'haa, 8'h55, 8'h99, 8'h3c};
  logic [31:0] wd [4] = '{32'h100, 32'h2bad, 32'h7, 32'h55};

  always #4 clk = ~clk;
  always @(posedge clk) if (cpu_restart === 1'b1) restarts++;

  otp_image_header_loader otp_image_header_loader_inst (.clk(clk), .rst_b(rst_b), .ce(ce), .start(start),
    .otp_o(otp_o), .otp_i(otp_i), .ram_o(ram_o), .ram_ready(ram_ready), .wb_i(wb_i), .wb_o(wb_o),
    .cfg(cfg), .normal_mode(normal_mode), .busy(busy), .done(done), .cpu_restart(cpu_restart), .remap(remap));
  otp_ram_model otp_ram_model_inst (.clk(clk), .rst_b(rst_b), .slow(slow), .req(otp_o), .rsp(otp_i),
    .wr(ram_o), .ready(ram_ready));

  // ************************
  // shared tasks
  // ************************
  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic put(input logic [15:0] badr, input logic [31:0] v);
    otp_ram_model_inst.mem[badr[14:2]] = v;
  endtask : put

  // classic cycle, held until ack is sampled, then released
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    @(posedge clk);
    wb_i <= '{1'b1, 1'b1, we, adr, 4'hf, d};
    do begin
      @(posedge clk);
    end while (wb_o.ack !== 1'b1);
    rd = wb_o.dat;
    wb_i <= '0;
    @(posedge clk);
    chk("wb ack drop", wb_o.ack, 0);
  endtask : wb

  // ctrl zero uses the start pin, otherwise a ctrl register write
  task automatic load(input logic [31:0] ctrl);
    int n;
    int r0;
    n = 0;
    r0 = restarts;
    if (ctrl == 0) begin
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
    end else wb(1'b1, 8'h00, ctrl);
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 5000);
    @(posedge clk);
    chk("restart pulse", restarts - r0, 1);
    chk("busy after load", busy, 0);
  endtask : load

  // ************************
  // tests
  // ************************
  initial begin
    foreach (otp_ram_model_inst.mem[i]) begin
      otp_ram_model_inst.mem[i] = '0;
      otp_ram_model_inst.ram[i] = '0;
    end
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    chk("reset state", {done, busy, remap}, 4'h0);
    // blank image boots into development mode without copying
    load(0);
    chk("blank normal", normal_mode, 0);
    chk("blank debug", cfg.debug_en, 1);
    chk("blank remap", remap, REMAP_SYSRAM);
    chk("blank writes", otp_ram_model_inst.writes, 0);
    // programmed image, slow partner; one blank word then a patch header after code
    slow <= 1'b1;
    for (int i = 0; i < 4; i++) put(16'(4 * i), wd[i]);
    put(16'h0014, 32'h0000_0bee);
    put(16'h7f00, 32'h1234a5a5);
    put(16'h7f04, 32'ha5a51234);
    put(16'h7ffc, {4{8'haa}});
    put(16'h7ff8, 32'd3);
    put(16'h7ff4, 32'h0);
    put(16'h7fd4, 32'h3322_1100);
    put(16'h7fd8, 32'h7766_5544);
    put(16'h7f78, 32'ha5a5_0025);
    for (int i = 0; i < 6; i++) put(16'h7f90 - 16'(4 * i), 32'h100 + i);
    put(16'h7f0c, 32'h106);
    put(16'h7f08, 32'h107);
    for (int i = 0; i < 15; i++) put(16'h7f94 + 16'(4 * i), 32'h5000 + i);
    load(0);
    chk("normal", normal_mode, 1);
    chk("debug off", cfg.debug_en, 0);
    chk("len", cfg.copy_len, 3);
    chk("bd addr", cfg.bd_addr, 64'h0011_2233_4455_6677);
    chk("cal done", cfg.cal_done, 1);
    chk("cal valid", cfg.cal_valid, 6'h25);
    for (int i = 0; i < 4; i++) chk("ram word", otp_ram_model_inst.ram[i], i < 3 ? wd[i] : 0);
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, 8'h20 + 8'(4 * i), 0);
      chk("trim", rd, 32'h100 + i);
    end
    for (int i = 0; i < 15; i++) begin
      wb(1'b0, 8'h40 + 8'(4 * i), 0);
      chk("sig word", rd, 32'h5000 + i);
    end
    wb(1'b1, 8'hfc, 32'hffff_ffff);
    wb(1'b0, 8'hfc, 0);
    chk("unmapped", rd, 0);
    wb(1'b0, 8'h08, 0);
    chk("len reg", rd, 3);
    wb(1'b0, 8'h04, 0);
    chk("status", rd, 32'h0001_6065);
    wb(1'b0, 8'h0c, 0);
    chk("cal reg", rd, 32'ha5a5_0025);
    wb(1'b0, 8'h10, 0);
    chk("bd hi", rd, 32'h0011_2233);
    wb(1'b0, 8'h14, 0);
    chk("bd lo", rd, 32'h4455_6677);
    // every flag code, an unknown one, partial replication, one app word only
    slow <= 1'b0;
    put(16'h7f04, 32'h0);
    put(16'h7f78, 32'h0000_003f);
    for (int i = 0; i < 5; i++) begin
      put(16'h7fd0, {4{sc[i]}});
      put(16'h7f70, {4{pc[i]}});
      put(16'h7f74, {4{i[0] ? 8'haa : 8'h00}});
      put(16'h7ffc, i == 1 ? 32'haaaa_aaaa : 32'h0000_00aa);
      load(i == 3 ? 32'h3 : 32'h0);
      chk("sig", cfg.sig, i < 4 ? i : 0);
      chk("pkg", cfg.pkg, i < 4 ? i : 0);
      chk("sleep", cfg.sleep_src, i[0]);
      chk("debug", cfg.debug_en, i != 1);
      chk("one app word", normal_mode, 0);
      chk("no magic", {cfg.cal_done, cfg.cal_valid}, 0);
      chk("remap", remap, i >= 3 ? REMAP_RETRAM : REMAP_SYSRAM);
    end
    chk("dev writes", otp_ram_model_inst.writes, 3);
    end_of_test();
  end

  // hang guard, far beyond the several hundred cycles the tests need
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
endmodule : test_otp_image_header_loader
